// file: rtl/ppb_regs.svh
`ifndef PPB_REGS_SVH
`define PPB_REGS_SVH
// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define PPB_ADDR_PRIO1   6'h00
`define PPB_ADDR_PRIO2   6'h04
`define PPB_ADDR_PRIO3   6'h08
`define PPB_ADDR_PRIO4   6'h0C
`define PPB_ADDR_PRIO5   6'h10
`define PPB_ADDR_PRIO6   6'h14
`define PPB_ADDR_RESET_CAUSE_CONTROL_REG    6'h18
`define PPB_ADDR_FLAG    6'h1C
`define PPB_ADDR_EN      6'h20
`define PPB_ADDR_MODE    6'h24
// ------------------------------------------------------------
// implemented-bit masks and reset values
// ------------------------------------------------------------
`define PPB_MASK1        8'hFF
`define PPB_MASK2        8'h8F
`define PPB_MASK3        8'h3E
`define PPB_MASK4        8'hF7
`define PPB_MASK5        8'hFF
`define PPB_MASK6        8'h00
`define PPB_PRIO_RST     8'hFF
`define PPB_RESET_CAUSE_CONTROL_REG_RST     8'h7C
`define PPB_RESET_CAUSE_CONTROL_REG_WMASK   8'hE3
`define PPB_PRIORITY_LEVELS_ENABLE_BIT     7
`define PPB_RXB0_BIT     0
`define PPB_MODE_RST     2'h0
`define PPB_MODE1        2'h1
`define PPB_RESP_OKAY    2'h0
`define PPB_RESP_SLVERR  2'h2
`endif

// file: rtl/ppb_pkg.sv
package ppb_pkg;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef logic [7:0]  ppb_byte_t;
   typedef logic [39:0] ppb_src_t;   // five registers of eight sources
   typedef logic [1:0]  ppb_mode_t;
endpackage

// file: rtl/ppb_route.sv
`timescale 1ns/1ps
`default_nettype none
// routes each pending source to the high or low request line
module ppb_route (
   input  wire ppb_pkg::ppb_src_t flag,
   input  wire ppb_pkg::ppb_src_t enable,
   input  wire ppb_pkg::ppb_src_t prio,
   input  wire logic              priority_levels_enable,
   output logic                   req_high,
   output logic                   req_low
);
   import ppb_pkg::*;
   ppb_src_t pend;
   ppb_src_t hi_vec;
   ppb_src_t lo_vec;
   genvar i;
   // per-source split by its priority bit
   generate
      for (i = 0; i < 40; i++) begin : g_src
         assign pend[i] = flag[i] & enable[i];
         // RULE15 route by bit
         // RULE3 one means high
         assign hi_vec[i] = pend[i] & (prio[i] | ~priority_levels_enable);
         assign lo_vec[i] = pend[i] & ~prio[i] & priority_levels_enable;
      end
   endgenerate
   // RULE14 single level when off
   assign req_high = |hi_vec;
   assign req_low  = |lo_vec;
endmodule // ppb_route
`default_nettype wire

// file: rtl/ppb_bank.sv
// Functional notes
// RULE1: six priority registers, one bit per source
// RULE2: priority bits honoured only when enable set
// RULE3: one is high priority, zero low
// RULE4: bits read/write, reset to one
// RULE5: unimplemented bits read as zero
// RULE6: register one maps port through timer1 overflow
// RULE7: register two oscillator, collision, voltage, timer3
// RULE8: register three serial2, charge unit, capture/compare
// RULE9: register four timer4, write, comparators, ccp
// RULE10: register five CAN errors and transmit buffers
// RULE11: bit one receive buffer or all messages
// RULE12: bit zero buffer0, absent, or fifo full
// RULE13: reset control holds cause bits and enable
// RULE14: enable clear gives single-level mode
// RULE15: pending source raises high or low request
//
// The register addresses and register access over AXI4-Lite were decided locally.
`include "ppb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ppb_bank (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [5:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [5:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire ppb_pkg::ppb_src_t   src_flag,
   input  wire logic [4:0]          reset_cause,
   output logic                     irq_high,
   output logic                     irq_low,
   output ppb_pkg::ppb_src_t        src_priority
);
   import ppb_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   ppb_byte_t prio_ff [0:4];
   ppb_byte_t reset_cause_control_reg_ff;
   ppb_src_t  en_ff;
   ppb_mode_t mode_ff;
   logic      aw_ff;
   logic      w_ff;
   logic [5:0]  awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic      aw_hit;
   logic      w_hit;
   logic      wr_go;
   logic      wr_ok;
   logic      rd_ok;
   logic [31:0] nxt_rdata;
   ppb_src_t  prio_eff;
   logic      req_high;
   logic      req_low;
   logic      irq_high_ff;
   logic      irq_low_ff;

   // ------------------------------------------------------------
   // write channel capture
   // ------------------------------------------------------------
   assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_ff & ~s_axi_bvalid;
   assign aw_hit = s_axi_awvalid & s_axi_awready;
   assign w_hit  = s_axi_wvalid & s_axi_wready;
   assign wr_go  = aw_ff & w_ff;

   // address and data held until both present
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ff     <= 1'b0;
         w_ff      <= 1'b0;
         awaddr_ff <= 6'h00;
         wdata_ff  <= 32'h0000_0000;
         wstrb_ff  <= 4'h0;
      end else begin
         if (aw_hit) begin
            aw_ff     <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_ff <= 1'b0;
         end
         if (w_hit) begin
            w_ff     <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end else if (wr_go) begin
            w_ff <= 1'b0;
         end
      end
   end

   // decode of every mapped address, read-only FLAG and PRIO6 included
   always_comb begin
      unique case (awaddr_ff)
         `PPB_ADDR_PRIO1, `PPB_ADDR_PRIO2, `PPB_ADDR_PRIO3,
         `PPB_ADDR_PRIO4, `PPB_ADDR_PRIO5, `PPB_ADDR_PRIO6,
         `PPB_ADDR_RESET_CAUSE_CONTROL_REG, `PPB_ADDR_EN, `PPB_ADDR_MODE,
         `PPB_ADDR_FLAG: wr_ok = 1'b1;
         default:        wr_ok = 1'b0;
      endcase
   end

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PPB_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? `PPB_RESP_OKAY : `PPB_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // priority registers
   // ------------------------------------------------------------
   localparam ppb_byte_t MASKS [0:4] = '{`PPB_MASK1, `PPB_MASK2,
      `PPB_MASK3, `PPB_MASK4, `PPB_MASK5};
   localparam logic [5:0] ADDRS [0:4] = '{`PPB_ADDR_PRIO1,
      `PPB_ADDR_PRIO2, `PPB_ADDR_PRIO3, `PPB_ADDR_PRIO4,
      `PPB_ADDR_PRIO5};
   genvar r;
   generate
      for (r = 0; r < 5; r++) begin : g_prio
         // RULE1 one register each
         // RULE4 reset to high
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               prio_ff[r] <= `PPB_PRIO_RST & MASKS[r];
            end else if (wr_go && awaddr_ff == ADDRS[r] && wstrb_ff[0]) begin
               // RULE5 unused bits kept zero
               prio_ff[r] <= wdata_ff[7:0] & MASKS[r];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // reset control, enable and mode registers
   // ------------------------------------------------------------
   // RULE13 cause bits and enable
   // cause clear beats a same-cycle write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reset_cause_control_reg_ff <= `PPB_RESET_CAUSE_CONTROL_REG_RST;
      end else if (wr_go && awaddr_ff == `PPB_ADDR_RESET_CAUSE_CONTROL_REG && wstrb_ff[0]) begin
         reset_cause_control_reg_ff <= ((wdata_ff[7:0] & `PPB_RESET_CAUSE_CONTROL_REG_WMASK)
                  | (reset_cause_control_reg_ff & ~`PPB_RESET_CAUSE_CONTROL_REG_WMASK)) & ~{3'h0, reset_cause};
      end else begin
         reset_cause_control_reg_ff[4:0] <= reset_cause_control_reg_ff[4:0] & ~reset_cause;  // cause flags
      end
   end

   // per-source enables
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_ff <= '0;
      end else if (wr_go && awaddr_ff == `PPB_ADDR_EN && wstrb_ff[0]) begin
         // one byte enables the same bit of every register
         en_ff <= {5{wdata_ff[7:0]}};
      end
   end

   // CAN controller mode selector
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_ff <= `PPB_MODE_RST;
      end else if (wr_go && awaddr_ff == `PPB_ADDR_MODE && wstrb_ff[0]) begin
         mode_ff <= wdata_ff[1:0];
      end
   end

   // ------------------------------------------------------------
   // effective priorities
   // ------------------------------------------------------------
   always_comb begin
      // RULE6 register one order
      // RULE7 register two order
      // RULE8 register three order
      // RULE9 register four order
      // RULE10 register five order
      prio_eff = {prio_ff[4], prio_ff[3], prio_ff[2], prio_ff[1],
                  prio_ff[0]};
      // RULE11 bit one shared meaning
      // RULE12 bit zero absent mode1
      if (mode_ff == `PPB_MODE1) begin
         prio_eff[32 + `PPB_RXB0_BIT] = 1'b0;
      end
   end
   assign src_priority = prio_eff;

   // RULE2 enable gates priorities
   ppb_route u_route (
      .flag     (src_flag),
      .enable   (en_ff),
      .prio     (prio_eff),
      .priority_levels_enable     (reset_cause_control_reg_ff[`PPB_PRIORITY_LEVELS_ENABLE_BIT]),
      .req_high (req_high),
      .req_low  (req_low)
   );

   // registered request outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_high_ff <= 1'b0;
         irq_low_ff  <= 1'b0;
      end else begin
         irq_high_ff <= req_high;
         irq_low_ff  <= req_low;
      end
   end
   assign irq_high = irq_high_ff;
   assign irq_low  = irq_low_ff;

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   assign s_axi_arready = ~s_axi_rvalid;

   // read data select
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      rd_ok     = 1'b1;
      unique case (s_axi_araddr)
         `PPB_ADDR_PRIO1: nxt_rdata[7:0] = prio_eff[7:0];
         `PPB_ADDR_PRIO2: nxt_rdata[7:0] = prio_eff[15:8];
         `PPB_ADDR_PRIO3: nxt_rdata[7:0] = prio_eff[23:16];
         `PPB_ADDR_PRIO4: nxt_rdata[7:0] = prio_eff[31:24];
         `PPB_ADDR_PRIO5: nxt_rdata[7:0] = prio_eff[39:32];
         `PPB_ADDR_PRIO6: nxt_rdata[7:0] = `PPB_MASK6;
         `PPB_ADDR_RESET_CAUSE_CONTROL_REG:  nxt_rdata[7:0] = reset_cause_control_reg_ff;
         `PPB_ADDR_FLAG:  nxt_rdata[7:0] = {6'h00, irq_high_ff, irq_low_ff};
         `PPB_ADDR_EN:    nxt_rdata[7:0] = en_ff[7:0];
         `PPB_ADDR_MODE:  nxt_rdata[1:0] = mode_ff;
         default:         rd_ok = 1'b0;
      endcase
   end

   // read response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `PPB_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= nxt_rdata;
         s_axi_rresp  <= rd_ok ? `PPB_RESP_OKAY : `PPB_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // ppb_bank
`default_nettype wire

// file: sim/ppb_bank_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// bus handshake checks
// ------------------------------------------------------------
module ppb_bank_checker (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        s_axi_awready,
   input  wire logic        s_axi_wready,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // read steps
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_r_wait;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   property p_rd_lat;
      s_ar_taken |=> s_axi_rvalid;
   endproperty
   property p_rd_hold;
      s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_rd_upper;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
   endproperty
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_r_once;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   property p_w_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   property p_b_once;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("late read");
   a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
   a_rd_upper: assert property (p_rd_upper) else $error("upper bits");
   a_ar_block: assert property (p_ar_block) else $error("ar open");
   a_r_once: assert property (p_r_once) else $error("rvalid kept");
   a_b_hold: assert property (p_b_hold) else $error("bvalid lost");
   a_w_block: assert property (p_w_block) else $error("aw open");
   a_b_once: assert property (p_b_once) else $error("bvalid kept");
endmodule // ppb_bank_checker
bind ppb_bank ppb_bank_checker chk_u (.aclk, .aresetn, .s_axi_awready,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// file: sim/ppb_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// core side bus master
// ------------------------------------------------------------
module ppb_core_model (
   input  wire logic        aclk,
   output logic [5:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [5:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   // idle bus at time zero
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
   end
   // write: both channels offered, each released when taken
   task automatic write(input logic [5:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [1:0] r, output bit ok);
      bit ta, tw, tb;
      ok = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (int n = 0; n < 200 && !ok; n++) begin
         #1;
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
         ok = tb;
      end
   endtask
   // read: address held until taken, rready until rvalid
   task automatic read(input logic [5:0] a, output logic [31:0] d,
         output logic [1:0] r, output bit ok);
      bit ta, tr;
      ok = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (int n = 0; n < 200 && !ok; n++) begin
         #1;
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) s_axi_rready <= 1'b0;
         ok = tr;
      end
   endtask
endmodule // ppb_core_model
`default_nettype wire

// file: sim/peripheral_irq_priority_bank_test.sv
`include "ppb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_priority_bank_test;
   import ppb_pkg::*;
   logic aclk = 0, aresetn = 0, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq_high, irq_low;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [4:0] reset_cause = '0;
   ppb_src_t src_flag = '0, src_priority, expv;
   ppb_byte_t msk[6] = '{8'hFF, 8'h8F, 8'h3E, 8'hF7, 8'hFF, 8'h00};
   ppb_byte_t pat[5] = '{8'hA5, 8'h3C, 8'h96, 8'h0F, 8'hC3};
   int fail_count = 0, num_checks = 0;
   // 200 MHz clock
   always #2.5 aclk = ~aclk;
   ppb_bank dut_u (.*);
   ppb_core_model core_u (.*);
   // compare and verdict
   task chk(string n, logic [39:0] e, logic [39:0] s);
      num_checks++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, s);
         fail_count++;
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task wr(logic [5:0] a, logic [7:0] d, logic [3:0] s, logic [1:0] er);
      logic [1:0] r;
      bit ok;
      core_u.write(a, {24'h00_0000, d}, s, r, ok);
      if (!ok) begin
         fail_count++;
         tally_and_finish;
      end
      chk("bresp", er, r);
   endtask
   task rd(logic [5:0] a, logic [7:0] e, logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      bit ok;
      core_u.read(a, d, r, ok);
      if (!ok) begin
         fail_count++;
         tally_and_finish;
      end
      chk("rdata", e, d);
      chk("rresp", er, r);
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(6'(i * 4), msk[i], 2'h0);
      rd(`PPB_ADDR_RESET_CAUSE_CONTROL_REG, 8'h7C, 2'h0);
      $display("test reset values done");
      for (int i = 0; i < 6; i++) begin
         wr(6'(i * 4), 8'h00, 4'h1, 2'h0);
         rd(6'(i * 4), 8'h00, 2'h0);
         wr(6'(i * 4), 8'hFF, 4'h1, 2'h0);
         rd(6'(i * 4), msk[i], 2'h0);
         wr(6'(i * 4), 8'h00, 4'h0, 2'h0);
         rd(6'(i * 4), msk[i], 2'h0);
      end
      $display("test access done");
      wr(`PPB_ADDR_RESET_CAUSE_CONTROL_REG, 8'h80, 4'h1, 2'h0);
      rd(`PPB_ADDR_RESET_CAUSE_CONTROL_REG, 8'h9C, 2'h0);
      reset_cause <= 5'h04;
      @(posedge aclk);
      reset_cause <= 5'h00;
      rd(`PPB_ADDR_RESET_CAUSE_CONTROL_REG, 8'h98, 2'h0);
      for (int i = 0; i < 5; i++) begin
         wr(6'(i * 4), pat[i], 4'h1, 2'h0);
         expv[i*8 +: 8] = pat[i] & msk[i];
      end
      chk("src_priority", expv, src_priority);
      wr(`PPB_ADDR_MODE, 8'h01, 4'h1, 2'h0);
      rd(`PPB_ADDR_PRIO5, 8'hC2, 2'h0);
      chk("mode1_bit", 1'b0, src_priority[32]);
      $display("test priority map done");
      wr(6'h2C, 8'h11, 4'h1, 2'h2);
      rd(6'h28, 8'h00, 2'h2);
      src_flag <= '1;
      rd(`PPB_ADDR_FLAG, 8'h00, 2'h0);
      wr(`PPB_ADDR_EN, 8'hFF, 4'h1, 2'h0);
      rd(`PPB_ADDR_EN, 8'hFF, 2'h0);
      rd(`PPB_ADDR_FLAG, 8'h03, 2'h0);
      chk("irq_high", 1'b1, irq_high);
      wr(`PPB_ADDR_RESET_CAUSE_CONTROL_REG, 8'h00, 4'h1, 2'h0);
      rd(`PPB_ADDR_FLAG, 8'h02, 2'h0);
      chk("irq_low", 1'b0, irq_low);
      chk("irq_high_single", 1'b1, irq_high);
      $display("test unmapped and requests done");
      tally_and_finish;
   end
endmodule // peripheral_irq_priority_bank_test
`default_nettype wire
